// ---- verilog/sicm_defs.vh ----
// Purpose: constants for the sixteen-input channel mapping block
// Assumes: plain Verilog-2005, included by bare name
// Notes:   byte offsets are word aligned on a 32-bit APB bus
`ifndef SICM_DEFS_VH
`define SICM_DEFS_VH

// ----------------------------------------
// register map
// ----------------------------------------
`define SICM_REG_CTRL      12'h000
`define SICM_REG_INSEL     12'h004
`define SICM_REG_PDN_DIG   12'h008
`define SICM_REG_PDN_ANA   12'h00c
`define SICM_REG_HPF       12'h010
`define SICM_REG_STATUS    12'h014
`define SICM_REG_GAIN_O    12'h040
`define SICM_REG_GAIN_E    12'h080
`define SICM_REG_OFS_O     12'h0c0
`define SICM_REG_OFS_E     12'h100
`define SICM_BANK_MASK     12'hfc0
`define SICM_IDX_HI        5
`define SICM_IDX_LO        2

// ----------------------------------------
// field layout and sizes
// ----------------------------------------
`define SICM_CTRL_RATE2X   0
`define SICM_CTRL_ENABLE   1
`define SICM_NCONV         16
`define SICM_NLANE         16
`define SICM_NGRP          4
`define SICM_GRP_SHIFT     2
`define SICM_HPF_W         4
`define SICM_CORNER_W      3
`define SICM_GAIN_W        6
`define SICM_OFS_W         10
`define SICM_WORD_W        14
`define SICM_LANE_W        28
`define SICM_FIFO_DEPTH    4
`define SICM_FIFO_AW       2
`define SICM_ZERO32        32'h00000000
`define SICM_ZERO16        16'h0000
`define SICM_FRAME_ONE     1'b0
`define SICM_FRAME_TWO     1'b1

`endif

// ---- verilog/sicm_fifo.v ----
// Purpose: small word FIFO with valid/ready on both sides
// Assumes: single clock, synchronous active-low reset
// Notes:   flip-flop storage, width and depth are parameters
`timescale 1ns/1ps
`include "sicm_defs.vh"

module sicm_fifo
#(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW    = 2
)
(
	// clock and reset
	input  wire             i_sys_clk,
	input  wire             i_rstn,
	// fill side
	input  wire             i_in_valid,
	input  wire [WIDTH-1:0] i_in_data,
	output wire             o_in_ready,
	// drain side
	output wire             o_out_valid,
	output wire [WIDTH-1:0] o_out_data,
	input  wire             i_out_ready
);

	reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_ff;
	reg [AW-1:0]    rd_ptr_ff;
	reg [AW:0]      count_ff;
	wire            push;
	wire            pop;

	// one slot is never wasted: count tells full from empty
	assign o_in_ready  = (count_ff != DEPTH[AW:0]);
	assign o_out_valid = (count_ff != {(AW+1){1'b0}});
	assign o_out_data  = mem_ff[rd_ptr_ff];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	always @(posedge i_sys_clk)
	begin
		if (!i_rstn)
		begin
			wr_ptr_ff <= {AW{1'b0}};
			rd_ptr_ff <= {AW{1'b0}};
			count_ff  <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
			begin
				mem_ff[wr_ptr_ff] <= i_in_data;
				wr_ptr_ff         <= wr_ptr_ff + 1'b1;
			end
			if (pop)
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			if (push && !pop)
				count_ff <= count_ff + 1'b1;
			else if (pop && !push)
				count_ff <= count_ff - 1'b1;
		end
	end

endmodule

// ---- verilog/sicm_top.v ----
// Purpose: sixteen-input mode converter-to-lane and setting-to-channel mapping
// Assumes: 20 MHz i_sys_clk, APB slave, converter words arrive in odd/even pairs
// Notes:   one pair of frames per accepted sample set, buffered four deep
//
// Functional notes
// - converters sample odd inputs by default, one converter per channel
// - per-converter select moves a converter to the next even input
// - select bit one picks even input; reset default is odd
// - converter settings act one-to-one as channel settings
// - 2X lanes pack two adjacent converters, odd frame then even frame
// - 2X uses lanes 1-4 and 9-12; other lanes carry nothing
// - converter digital/analog power-down act as channel power-downs
// - high-pass enable and corner shared by groups of four
// - 1X gives each converter its own lane, odd then even frame
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`include "sicm_defs.vh"

module sicm_top
(
	// clock and reset
	input  wire                                   i_sys_clk,
	input  wire                                   i_rstn,
	// apb slave
	input  wire                                   i_psel,
	input  wire                                   i_penable,
	input  wire                                   i_pwrite,
	input  wire [11:0]                            i_paddr,
	input  wire [31:0]                            i_pwdata,
	output reg  [31:0]                            o_prdata,
	output wire                                   o_pready,
	output wire                                   o_pslverr,
	// converter sample pairs, all 16 converters side by side
	input  wire                                   i_smp_valid,
	input  wire [`SICM_NCONV*`SICM_WORD_W-1:0]    i_odd_sample_word,
	input  wire [`SICM_NCONV*`SICM_WORD_W-1:0]    i_even_sample_word,
	output wire                                   o_smp_ready,
	// lane output, one frame per strobe
	output reg  [`SICM_NLANE*`SICM_LANE_W-1:0]    o_lane_data,
	output reg  [`SICM_NLANE-1:0]                 o_lane_active,
	output reg                                    o_frame_valid,
	output reg                                    o_frame_second,
	input  wire                                   i_frame_ready,
	// per-channel settings toward the analog front end
	output wire [`SICM_NCONV-1:0]                 o_even_input_select,
	output wire [`SICM_NCONV-1:0]                 o_converter_digital_powerdown,
	output wire [`SICM_NCONV-1:0]                 o_converter_analog_powerdown,
	output wire [`SICM_NCONV-1:0]                 o_highpass_filter_enable,
	output wire [`SICM_NCONV*`SICM_CORNER_W-1:0]  o_highpass_corner_select,
	output wire [`SICM_NCONV*`SICM_GAIN_W-1:0]    o_odd_sample_gain,
	output wire [`SICM_NCONV*`SICM_GAIN_W-1:0]    o_even_sample_gain,
	output wire [`SICM_NCONV*`SICM_OFS_W-1:0]     o_odd_sample_offset,
	output wire [`SICM_NCONV*`SICM_OFS_W-1:0]     o_even_sample_offset
);

	localparam PAIR_W = 2*`SICM_NCONV*`SICM_WORD_W;
	localparam ST_IDLE = 2'b00;
	localparam ST_ODD  = 2'b01;
	localparam ST_EVEN = 2'b10;

	// ----------------------------------------
	// register file
	// ----------------------------------------
	reg                         rate2x_ff;
	reg                         enable_ff;
	reg [`SICM_NCONV-1:0]       insel_ff;
	reg [`SICM_NCONV-1:0]       pdn_dig_ff;
	reg [`SICM_NCONV-1:0]       pdn_ana_ff;
	reg [`SICM_HPF_W-1:0]       hpf_en_ff;
	reg [`SICM_HPF_W*`SICM_CORNER_W-1:0] hpf_corner_ff;
	reg [`SICM_GAIN_W-1:0]      gain_o_ff [0:`SICM_NCONV-1];
	reg [`SICM_GAIN_W-1:0]      gain_e_ff [0:`SICM_NCONV-1];
	reg [`SICM_OFS_W-1:0]       ofs_o_ff  [0:`SICM_NCONV-1];
	reg [`SICM_OFS_W-1:0]       ofs_e_ff  [0:`SICM_NCONV-1];
	reg [15:0]                  frame_cnt_ff;

	wire       apb_acc = i_psel & i_penable;
	wire       apb_wr  = apb_acc & i_pwrite;
	wire [3:0] cidx    = i_paddr[`SICM_IDX_HI:`SICM_IDX_LO];

	// table banks: 16 words each
	function is_bank;
		input [11:0] addr;
		input [11:0] base;
		begin
			is_bank = ((addr & `SICM_BANK_MASK) == base);
		end
	endfunction

	function is_mapped;
		input [11:0] addr;
		begin
			is_mapped = (addr == `SICM_REG_CTRL) || (addr == `SICM_REG_INSEL)
				|| (addr == `SICM_REG_PDN_DIG) || (addr == `SICM_REG_PDN_ANA)
				|| (addr == `SICM_REG_HPF) || (addr == `SICM_REG_STATUS)
				|| (is_bank(addr, `SICM_REG_GAIN_O) && addr[1:0] == 2'b00)
				|| (is_bank(addr, `SICM_REG_GAIN_E) && addr[1:0] == 2'b00)
				|| (is_bank(addr, `SICM_REG_OFS_O) && addr[1:0] == 2'b00)
				|| (is_bank(addr, `SICM_REG_OFS_E) && addr[1:0] == 2'b00);
		end
	endfunction

	// zero wait states; unmapped answers with pslverr
	assign o_pready  = 1'b1;
	assign o_pslverr = apb_acc & ~is_mapped(i_paddr);

	always @(posedge i_sys_clk)
	begin
		if (!i_rstn)
		begin
			rate2x_ff     <= 1'b0;
			enable_ff     <= 1'b0;
			insel_ff      <= `SICM_ZERO16;    // odd inputs after reset
			pdn_dig_ff    <= `SICM_ZERO16;
			pdn_ana_ff    <= `SICM_ZERO16;
			hpf_en_ff     <= {`SICM_HPF_W{1'b0}};
			hpf_corner_ff <= {(`SICM_HPF_W*`SICM_CORNER_W){1'b0}};
		end
		else if (apb_wr)
		begin
			case (i_paddr)
			`SICM_REG_CTRL:
			begin
				rate2x_ff <= i_pwdata[`SICM_CTRL_RATE2X];
				enable_ff <= i_pwdata[`SICM_CTRL_ENABLE];
			end
			`SICM_REG_INSEL:   insel_ff   <= i_pwdata[15:0];
			`SICM_REG_PDN_DIG: pdn_dig_ff <= i_pwdata[15:0];
			`SICM_REG_PDN_ANA: pdn_ana_ff <= i_pwdata[15:0];
			`SICM_REG_HPF:
			begin
				hpf_en_ff     <= i_pwdata[3:0];
				hpf_corner_ff <= i_pwdata[15:4];
			end
			default: ;
			endcase
		end
	end

	// gain/offset tables; odd and even kept apart, software keeps them equal
	always @(posedge i_sys_clk)
	begin
		if (apb_wr && i_paddr[1:0] == 2'b00)
		begin
			if (is_bank(i_paddr, `SICM_REG_GAIN_O))
				gain_o_ff[cidx] <= i_pwdata[`SICM_GAIN_W-1:0];
			if (is_bank(i_paddr, `SICM_REG_GAIN_E))
				gain_e_ff[cidx] <= i_pwdata[`SICM_GAIN_W-1:0];
			if (is_bank(i_paddr, `SICM_REG_OFS_O))
				ofs_o_ff[cidx] <= i_pwdata[`SICM_OFS_W-1:0];
			if (is_bank(i_paddr, `SICM_REG_OFS_E))
				ofs_e_ff[cidx] <= i_pwdata[`SICM_OFS_W-1:0];
		end
	end

	always @*
	begin
		o_prdata = `SICM_ZERO32;
		if (apb_acc && !i_pwrite)
		begin
			if (i_paddr == `SICM_REG_CTRL)
				o_prdata = {30'h0, enable_ff, rate2x_ff};
			else if (i_paddr == `SICM_REG_INSEL)
				o_prdata = {16'h0, insel_ff};
			else if (i_paddr == `SICM_REG_PDN_DIG)
				o_prdata = {16'h0, pdn_dig_ff};
			else if (i_paddr == `SICM_REG_PDN_ANA)
				o_prdata = {16'h0, pdn_ana_ff};
			else if (i_paddr == `SICM_REG_HPF)
				o_prdata = {16'h0, hpf_corner_ff, hpf_en_ff};
			else if (i_paddr == `SICM_REG_STATUS)
				o_prdata = {13'h0, o_frame_second, o_frame_valid, o_smp_ready, frame_cnt_ff};
			else if (is_bank(i_paddr, `SICM_REG_GAIN_O))
				o_prdata = {26'h0, gain_o_ff[cidx]};
			else if (is_bank(i_paddr, `SICM_REG_GAIN_E))
				o_prdata = {26'h0, gain_e_ff[cidx]};
			else if (is_bank(i_paddr, `SICM_REG_OFS_O))
				o_prdata = {22'h0, ofs_o_ff[cidx]};
			else if (is_bank(i_paddr, `SICM_REG_OFS_E))
				o_prdata = {22'h0, ofs_e_ff[cidx]};
		end
	end

	// ----------------------------------------
	// per-channel settings
	// ----------------------------------------
	assign o_even_input_select           = insel_ff;
	assign o_converter_digital_powerdown = pdn_dig_ff;
	assign o_converter_analog_powerdown  = pdn_ana_ff;

	genvar g;
	generate
		for (g = 0; g < `SICM_NCONV; g = g + 1)
		begin : g_chan
			localparam GRP = g >> `SICM_GRP_SHIFT;
			// one shared setting fans out to four channels
			assign o_highpass_filter_enable[g] = hpf_en_ff[GRP];
			assign o_highpass_corner_select[g*`SICM_CORNER_W +: `SICM_CORNER_W] =
				hpf_corner_ff[GRP*`SICM_CORNER_W +: `SICM_CORNER_W];
			assign o_odd_sample_gain[g*`SICM_GAIN_W +: `SICM_GAIN_W]   = gain_o_ff[g];
			assign o_even_sample_gain[g*`SICM_GAIN_W +: `SICM_GAIN_W]  = gain_e_ff[g];
			assign o_odd_sample_offset[g*`SICM_OFS_W +: `SICM_OFS_W]   = ofs_o_ff[g];
			assign o_even_sample_offset[g*`SICM_OFS_W +: `SICM_OFS_W]  = ofs_e_ff[g];
		end
	endgenerate

	// ----------------------------------------
	// sample buffer
	// ----------------------------------------
	wire              fifo_in_ready;
	wire              fifo_out_valid;
	wire [PAIR_W-1:0] fifo_out_data;
	reg               fifo_pop;

	// disabled block stalls the converters rather than dropping words
	assign o_smp_ready = fifo_in_ready & enable_ff;

	sicm_fifo
	#(
		.WIDTH (PAIR_W),
		.DEPTH (`SICM_FIFO_DEPTH),
		.AW    (`SICM_FIFO_AW)
	)
	u_fifo
	(
		.i_sys_clk   (i_sys_clk),
		.i_rstn      (i_rstn),
		.i_in_valid  (i_smp_valid & enable_ff),
		.i_in_data   ({i_even_sample_word, i_odd_sample_word}),
		.o_in_ready  (fifo_in_ready),
		.o_out_valid (fifo_out_valid),
		.o_out_data  (fifo_out_data),
		.i_out_ready (fifo_pop)
	);

	// ----------------------------------------
	// lane packing
	// ----------------------------------------
	// build one frame from the head pair; sel_even picks the second instant
	function [`SICM_NLANE*`SICM_LANE_W-1:0] pack_lanes;
		input [PAIR_W-1:0] pair;
		input              sel_even;
		input              two_x;
		reg   [`SICM_NCONV*`SICM_WORD_W-1:0] w;
		integer l;
		integer c;
		begin
			w = sel_even ? pair[PAIR_W-1 -: `SICM_NCONV*`SICM_WORD_W]
				: pair[`SICM_NCONV*`SICM_WORD_W-1:0];
			pack_lanes = {(`SICM_NLANE*`SICM_LANE_W){1'b0}};
			for (l = 0; l < `SICM_NLANE; l = l + 1)
			begin
				if (!two_x)
					// own lane, word in the low half
					pack_lanes[l*`SICM_LANE_W +: `SICM_WORD_W] = w[l*`SICM_WORD_W +: `SICM_WORD_W];
				else if (l < 4 || (l >= 8 && l < 12))
				begin
					// lanes 1-4 take converters 1-8, lanes 9-12 take 9-16
					c = (l < 4) ? 2*l : 2*(l-8)+8;
					// lower-numbered converter first in the lane word
					pack_lanes[l*`SICM_LANE_W +: `SICM_LANE_W] =
						{w[c*`SICM_WORD_W +: `SICM_WORD_W], w[(c+1)*`SICM_WORD_W +: `SICM_WORD_W]};
				end
			end
		end
	endfunction

	function [`SICM_NLANE-1:0] lane_mask;
		input two_x;
		begin
			lane_mask = two_x ? 16'h0f0f : 16'hffff;
		end
	endfunction

	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	wire      hs = o_frame_valid & i_frame_ready;

	always @*
	begin
		nxt_state = state_ff;
		fifo_pop  = 1'b0;
		case (state_ff)
		ST_IDLE: if (fifo_out_valid) nxt_state = ST_ODD;
		ST_ODD:  if (hs) nxt_state = ST_EVEN;
		ST_EVEN:
		begin
			if (hs)
			begin
				fifo_pop  = 1'b1;
				nxt_state = ST_IDLE;
			end
		end
		default: nxt_state = ST_IDLE;
		endcase
	end

	// rate latched per frame pair so a pair is never split across modes
	reg rate_lat_ff;

	always @(posedge i_sys_clk)
	begin
		if (!i_rstn)
		begin
			state_ff       <= ST_IDLE;
			o_frame_valid  <= 1'b0;
			o_frame_second <= `SICM_FRAME_ONE;
			o_lane_data    <= {(`SICM_NLANE*`SICM_LANE_W){1'b0}};
			o_lane_active  <= `SICM_ZERO16;
			rate_lat_ff    <= 1'b0;
			frame_cnt_ff   <= `SICM_ZERO16;
		end
		else
		begin
			state_ff <= nxt_state;
			if (state_ff == ST_IDLE && fifo_out_valid)
			begin
				// odd samples first: first instant
				rate_lat_ff    <= rate2x_ff;
				o_lane_data    <= pack_lanes(fifo_out_data, `SICM_FRAME_ONE, rate2x_ff);
				o_lane_active  <= lane_mask(rate2x_ff);
				o_frame_second <= `SICM_FRAME_ONE;
				o_frame_valid  <= 1'b1;
			end
			else if (state_ff == ST_ODD && hs)
			begin
				o_lane_data    <= pack_lanes(fifo_out_data, `SICM_FRAME_TWO, rate_lat_ff);
				o_frame_second <= `SICM_FRAME_TWO;
				frame_cnt_ff   <= frame_cnt_ff + 1'b1;
			end
			else if (state_ff == ST_EVEN && hs)
			begin
				o_frame_valid  <= 1'b0;
				o_frame_second <= `SICM_FRAME_ONE;
				frame_cnt_ff   <= frame_cnt_ff + 1'b1;
			end
		end
	end

endmodule

// ---- tb/sicm_top_properties.sv ----
// Purpose: port-level temporal checks on the mapping block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every sicm_top instance
`timescale 1ns/1ps
module sicm_props
(
	// clock and reset
	input wire logic         i_sys_clk,
	input wire logic         i_rstn,
	// apb
	input wire logic         i_psel,
	input wire logic         i_penable,
	input wire logic         i_pwrite,
	input wire logic [11:0]  i_paddr,
	input wire logic [31:0]  i_pwdata,
	input wire logic         o_pready,
	// frames
	input wire logic [447:0] o_lane_data,
	input wire logic [15:0]  o_lane_active,
	input wire logic         o_frame_valid,
	input wire logic         o_frame_second,
	input wire logic         i_frame_ready,
	// settings
	input wire logic [15:0]  o_even_input_select,
	input wire logic [15:0]  o_converter_digital_powerdown,
	input wire logic [15:0]  o_converter_analog_powerdown,
	input wire logic [15:0]  o_highpass_filter_enable
);
	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);
	wire wr = i_psel && i_penable && o_pready && i_pwrite;
	chk_insel_write: assert property (
		wr && i_paddr == 12'h004 |=> o_even_input_select == $past(i_pwdata[15:0]))
		else $error("input select differs from write");
	chk_pdn_digital: assert property (
		wr && i_paddr == 12'h008 |=> o_converter_digital_powerdown == $past(i_pwdata[15:0]))
		else $error("digital power-down differs from write");
	chk_pdn_analog: assert property (
		wr && i_paddr == 12'h00c |=> o_converter_analog_powerdown == $past(i_pwdata[15:0]))
		else $error("analog power-down differs from write");
	chk_hpf_group: assert property (
		wr && i_paddr == 12'h010 |=> o_highpass_filter_enable == {{4{$past(i_pwdata[3])}},
		{4{$past(i_pwdata[2])}}, {4{$past(i_pwdata[1])}}, {4{$past(i_pwdata[0])}}})
		else $error("filter enable not shared by four");
	chk_active_set: assert property (
		o_frame_valid |-> o_lane_active == 16'hffff || o_lane_active == 16'h0f0f)
		else $error("bad active lane set");
	chk_idle_lanes: assert property (
		o_frame_valid && o_lane_active == 16'h0f0f
		|-> o_lane_data[223:112] == 0 && o_lane_data[447:336] == 0)
		else $error("unused lanes carry data");
	chk_pad_single: assert property (
		o_frame_valid && o_lane_active == 16'hffff
		|-> o_lane_data[27:14] == 0 && o_lane_data[447:434] == 0)
		else $error("single rate lane upper bits set");
	chk_pair_order: assert property (
		o_frame_valid && i_frame_ready && !o_frame_second |=> o_frame_valid && o_frame_second)
		else $error("frame two does not follow frame one");
	chk_frame_hold: assert property (
		o_frame_valid && !i_frame_ready
		|=> o_frame_valid && $stable(o_lane_data) && $stable(o_frame_second))
		else $error("frame changed before taken");
	chk_pair_end: assert property (
		o_frame_valid && o_frame_second && i_frame_ready |=> !o_frame_valid)
		else $error("no gap after frame two");
endmodule

bind sicm_top sicm_props chk_u (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
	.o_pready(o_pready), .o_lane_data(o_lane_data), .o_lane_active(o_lane_active),
	.o_frame_valid(o_frame_valid), .o_frame_second(o_frame_second),
	.i_frame_ready(i_frame_ready), .o_even_input_select(o_even_input_select),
	.o_converter_digital_powerdown(o_converter_digital_powerdown),
	.o_converter_analog_powerdown(o_converter_analog_powerdown),
	.o_highpass_filter_enable(o_highpass_filter_enable));

// ---- tb/sicm_rx_model.sv ----
// Purpose: receiver stand-in that takes frames with random stalls
// Assumes: a frame is taken on valid and ready at a rising edge
// Notes:   i_hold parks it so the buffer can fill
`timescale 1ns/1ps
module sicm_rx_model
(
	// clock, reset and control
	input  wire logic i_sys_clk,
	input  wire logic i_rstn,
	input  wire logic i_hold,
	// frame handshake
	output logic      o_frame_ready
);
	// ----------------------------------------
	// ready
	// ----------------------------------------
	// stalls at random so held frames get exercised
	always @(posedge i_sys_clk)
	begin
		o_frame_ready <= i_rstn && !i_hold && ($urandom % 3 != 0);
	end
endmodule

// ---- tb/tb.sv ----
// Purpose: self-checking bench for the sixteen-input mapping block
// Assumes: 20 MHz clock, zero-wait apb slave, receiver model
// Notes:   drivers queue expectations, monitors compare
`timescale 1ns/1ps
module tb;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, sv = 0, hold = 1;
	logic [11:0] pa = 0;
	logic [31:0] pwd = 0;
	logic [223:0] ow = 0, ew = 0;
	wire [31:0] prd;
	wire prdy, perr, sready, fv, f2, rdy;
	wire [447:0] ld;
	wire [15:0] la, insel, pdd, pda, hen;
	wire [47:0] hcs;
	wire [95:0] go, ge;
	wire [159:0] oo, oe;
	int n_mismatch = 0, samples_checked = 0;
	logic [32:0] q_rd[$];
	logic [464:0] q_fr[$];

	initial forever #25 clk = ~clk;

	sicm_top dut_u (.i_sys_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy),
		.o_pslverr(perr), .i_smp_valid(sv), .i_odd_sample_word(ow),
		.i_even_sample_word(ew), .o_smp_ready(sready), .o_lane_data(ld),
		.o_lane_active(la), .o_frame_valid(fv), .o_frame_second(f2),
		.i_frame_ready(rdy), .o_even_input_select(insel),
		.o_converter_digital_powerdown(pdd), .o_converter_analog_powerdown(pda),
		.o_highpass_filter_enable(hen), .o_highpass_corner_select(hcs),
		.o_odd_sample_gain(go), .o_even_sample_gain(ge), .o_odd_sample_offset(oo),
		.o_even_sample_offset(oe));
	sicm_rx_model rx_u (.i_sys_clk(clk), .i_rstn(rstn), .i_hold(hold), .o_frame_ready(rdy));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic cmp_w(input logic [32:0] got, input logic [32:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_fr(input logic [464:0] got, input logic [464:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1;
		@(posedge clk);
		while (prdy !== 1'b1) @(posedge clk);
		psel <= 0;
		pen <= 0;
	endtask
	function automatic logic [223:0] rnd();
		return {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
	endfunction
	// receiver view: lane demux depends on the configured rate
	function automatic logic [464:0] fr_exp(input logic [223:0] w, input logic x2, sec);
		logic [447:0] l;
		logic [15:0] a;
		l = '0;
		a = x2 ? 16'h0f0f : 16'hffff;
		for (int i = 0; i < 16; i++)
			if (!x2)
				l[28*i +: 28] = {14'h0, w[14*i +: 14]};
			else if (a[i])
				l[28*i +: 28] = {w[14*(2*i-8*(i/8)) +: 14],
					w[14*(2*i-8*(i/8))+14 +: 14]};
		return {sec, a, l};
	endfunction
	// keeps valid up; the caller lowers it after the last set
	task automatic send(input logic x2);
		logic [223:0] o, e;
		o = rnd();
		e = rnd();
		ow <= o;
		ew <= e;
		sv <= 1;
		q_fr.push_back(fr_exp(o, x2, 0));
		q_fr.push_back(fr_exp(e, x2, 1));
		@(posedge clk);
		while (sready !== 1'b1) @(posedge clk);
	endtask

	// ----------------------------------------
	// monitors
	// ----------------------------------------
	always @(posedge clk)
		if (psel && pen && prdy === 1'b1 && !pwr)
			cmp_w({perr, prd}, q_rd.pop_front());
	always @(posedge clk)
		if (fv === 1'b1 && rdy === 1'b1)
			cmp_fr({f2, la, ld}, q_fr.pop_front());
	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		close_out();
	end

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial
	begin
		logic [31:0] r, g, f;
		void'($urandom(26));
		repeat (20) @(posedge clk);
		rstn <= 1;
		for (int k = 0; k < 5; k++)
		begin
			q_rd.push_back(33'h0);
			apb(0, 12'(4*k), 0);
		end
		cmp_w(insel, 0);
		cmp_w(sready, 0);
		for (int k = 0; k < 3; k++)
		begin
			r = $urandom & 32'hffff;
			apb(1, 12'(4 + 4*k), r);
			q_rd.push_back({1'b0, r});
			apb(0, 12'(4 + 4*k), 0);
			cmp_w(k == 0 ? insel : k == 1 ? pdd : pda, r);
		end
		r = $urandom & 32'hffff;
		apb(1, 12'h010, r);
		@(posedge clk);
		for (int k = 0; k < 16; k++)
			cmp_w({hen[k], hcs[3*k +: 3]}, {r[k/4], r[4+3*(k/4) +: 3]});
		for (int k = 0; k < 16; k++)
		begin
			g = $urandom % 64;
			f = $urandom % 1024;
			apb(1, 12'(64 + 4*k), g);
			apb(1, 12'(128 + 4*k), g);
			apb(1, 12'(192 + 4*k), f);
			apb(1, 12'(256 + 4*k), f);
			@(posedge clk);
			cmp_w({go[6*k +: 6], ge[6*k +: 6], oo[10*k +: 10], oe[10*k +: 10]},
				{g[5:0], g[5:0], f[9:0], f[9:0]});
		end
		q_rd.push_back({1'b1, 32'h0});
		apb(0, 12'h018, 0);
		for (int x = 0; x < 2; x++)
		begin
			apb(1, 12'h000, 32'(2 + x));
			hold <= 1;
			// four sets fill the buffer; a fifth would wait for a parked receiver
			repeat (4) send(x[0]);
			sv <= 0;
			repeat (3) @(posedge clk);
			cmp_w(sready, 0);
			hold <= 0;
			repeat (3) send(x[0]);
			sv <= 0;
			while (q_fr.size() != 0) @(posedge clk);
		end
		close_out();
	end
endmodule
